// >>> design/drive_mode_and_input_config.v
`timescale 1ns/10ps
`include "drive_cfg_map.vh"

module drive_mode_and_input_config
(
	// clock and reset
	input wire core_clk,
	input wire arst_n,
	// object access from the fieldbus side
	input wire obj_req,
	input wire obj_wr,
	input wire [15:0] obj_index,
	input wire [7:0] obj_sub,
	input wire [31:0] obj_wdata,
	output reg obj_ack,
	output reg obj_err,
	output reg [31:0] obj_rdata,
	// raw digital input pins, input_one at bit 0, input_five_pin at bit 4
	input wire [4:0] input_pin,
	// motion side
	input wire enable_request,
	output wire enable_grant,
	output wire [7:0] active_mode,
	output wire limit_negative,
	output wire limit_positive,
	output wire home_signal,
	output wire quick_stop,
	output wire probe1,
	output wire probe2
);

	reg [15:0] func_sel [0:4];
	reg [15:0] filter_us [0:4];
	reg [15:0] active_level;
	reg [7:0] mode_select;
	reg [6:0] tick_cnt;
	reg us_tick;
	reg [31:0] next_rdata;
	reg next_err;
	wire [4:0] filtered;
	wire [4:0] active;
	wire [79:0] func_flat;
	wire [31:0] supported_modes;
	wire [15:0] phys_state;
	wire [31:0] func_status;
	wire [4:0] user_mask;
	wire mode_supported;
	wire sub_in_array;
	wire [2:0] sub_slot;

	// code is 0 or one of the seven one-hot function codes
	function code_ok;
		input [15:0] code;
		begin
			code_ok = (code == `FN_NONE) | (code == `FN_HOMING) |
				(code == `FN_POS_LIMIT) | (code == `FN_NEG_LIMIT) |
				(code == `FN_EMERGENCY_STOP) | (code == `FN_USER_DEFINED) |
				(code == `FN_PROBE1) | (code == `FN_PROBE2);
		end
	endfunction

	// which inputs are mapped to the given function
	function [4:0] inputs_with;
		input [79:0] sel;
		input [15:0] code;
		integer k;
		begin
			inputs_with = 5'h00;
			for (k = 0; k < `NUM_INPUTS; k = k + 1)
				inputs_with[k] = (sel[k*16 +: 16] == code);
		end
	endfunction

	// shared microsecond tick keeps each filter counter at 16 bits
	always @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			tick_cnt <= 7'h00;
			us_tick <= 1'b0;
		end
		else if (tick_cnt == (`US_TICK_CYCLES - 1))
		begin
			tick_cnt <= 7'h00;
			us_tick <= 1'b1;
		end
		else
		begin
			tick_cnt <= tick_cnt + 7'h01;
			us_tick <= 1'b0;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < `NUM_INPUTS; gi = gi + 1)
		begin : g_in
			input_debounce u_debounce
			(
				.core_clk(core_clk),
				.arst_n(arst_n),
				.us_tick(us_tick),
				.filter_us(filter_us[gi]),
				.raw(input_pin[gi]),
				.level(filtered[gi])
			);
			// polarity applied before mapping and status
			assign active[gi] = active_level[gi] ? filtered[gi] : ~filtered[gi];
			assign func_flat[gi*16 +: 16] = func_sel[gi];
		end
	endgenerate

	mode_tracker u_mode
	(
		.core_clk(core_clk),
		.arst_n(arst_n),
		.mode_select(mode_select),
		.mode_display(active_mode),
		.mode_supported(mode_supported),
		.enable_request(enable_request),
		.enable_grant(enable_grant)
	);

	assign limit_negative = |(active & inputs_with(func_flat, `FN_NEG_LIMIT));
	assign limit_positive = |(active & inputs_with(func_flat, `FN_POS_LIMIT));
	assign home_signal = |(active & inputs_with(func_flat, `FN_HOMING));
	assign quick_stop = |(active & inputs_with(func_flat, `FN_EMERGENCY_STOP));
	assign probe1 = |(active & inputs_with(func_flat, `FN_PROBE1));
	assign probe2 = |(active & inputs_with(func_flat, `FN_PROBE2));
	assign user_mask = active & inputs_with(func_flat, `FN_USER_DEFINED);

	assign supported_modes = (32'h00000001 << `SUPP_BIT_PROFILE_POSITION) |
		(32'h00000001 << `SUPP_BIT_PROFILE_VELOCITY) |
		(32'h00000001 << `SUPP_BIT_HOMING) |
		(32'h00000001 << `SUPP_BIT_CYCLIC_SYNC_POSITION);

	assign phys_state = {11'h000, active};

	// reserved status bits are hard zero
	assign func_status = (32'h00000001 << `FS_NEG_LIMIT) & {32{limit_negative}} |
		(32'h00000001 << `FS_POS_LIMIT) & {32{limit_positive}} |
		(32'h00000001 << `FS_HOME) & {32{home_signal}} |
		(32'h00000001 << `FS_QUICK_STOP) & {32{quick_stop}} |
		({27'h0000000, user_mask} << `FS_USER_LSB) |
		(32'h00000001 << `FS_PROBE1) & {32{probe1}} |
		(32'h00000001 << `FS_PROBE2) & {32{probe2}};

	assign sub_in_array = (obj_sub >= 8'h01) && (obj_sub <= 8'h05);
	assign sub_slot = obj_sub[2:0] - 3'h1;

	// read mux and access check, answered one cycle after the request
	always @*
	begin
		next_rdata = 32'h00000000;
		next_err = 1'b0;
		if ((obj_index == `IDX_FUNC_SELECT) || (obj_index == `IDX_FILTER_TIME))
		begin
			if (obj_sub == `SUB_COUNT)
			begin
				next_rdata = `SUB_COUNT_VALUE;
				next_err = obj_wr;
			end
			else if (!sub_in_array)
				next_err = 1'b1;
			else if (obj_index == `IDX_FUNC_SELECT)
			begin
				next_rdata = {16'h0000, func_sel[sub_slot]};
				next_err = obj_wr && !(code_ok(obj_wdata[15:0]) && (obj_wdata[31:16] == 16'h0000));
			end
			else
			begin
				next_rdata = {16'h0000, filter_us[sub_slot]};
				next_err = obj_wr && ((obj_wdata[31:16] != 16'h0000) ||
					(obj_wdata[15:0] < `FILTER_US_MIN) ||
					(obj_wdata[15:0] > `FILTER_US_MAX));
			end
		end
		else if (obj_sub != 8'h00)
			next_err = 1'b1;
		else if (obj_index == `IDX_ACTIVE_LEVEL)
		begin
			next_rdata = {16'h0000, active_level};
			next_err = obj_wr && (obj_wdata[31:16] != 16'h0000);
		end
		else if (obj_index == `IDX_PHYS_STATE)
		begin
			next_rdata = {16'h0000, phys_state};
			next_err = obj_wr;
		end
		else if (obj_index == `IDX_MODE_SELECT)
		begin
			next_rdata = {24'h000000, mode_select};
			next_err = obj_wr && (obj_wdata[31:8] != 24'h000000);
		end
		else if (obj_index == `IDX_MODE_DISPLAY)
		begin
			next_rdata = {24'h000000, active_mode};
			next_err = obj_wr;
		end
		else if (obj_index == `IDX_FUNC_STATUS)
		begin
			next_rdata = func_status;
			next_err = obj_wr;
		end
		else if (obj_index == `IDX_SUPPORTED_MODES)
		begin
			next_rdata = supported_modes;
			next_err = obj_wr;
		end
		else
			next_err = 1'b1;
	end

	// answer port
	always @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			obj_ack <= 1'b0;
			obj_err <= 1'b0;
			obj_rdata <= 32'h00000000;
		end
		else
		begin
			obj_ack <= obj_req;
			obj_err <= obj_req & next_err;
			obj_rdata <= (obj_req && !obj_wr) ? next_rdata : 32'h00000000;
		end
	end

	// configuration storage, a refused write changes nothing
	always @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			func_sel[0] <= `FUNC_RST_INPUT1;
			func_sel[1] <= `FUNC_RST_INPUT2;
			func_sel[2] <= `FUNC_RST_INPUT3;
			func_sel[3] <= `FUNC_RST_INPUT4;
			func_sel[4] <= `FUNC_RST_INPUT5;
			filter_us[0] <= `FILTER_US_RST;
			filter_us[1] <= `FILTER_US_RST;
			filter_us[2] <= `FILTER_US_RST;
			filter_us[3] <= `FILTER_US_RST;
			filter_us[4] <= `FILTER_US_RST;
			active_level <= `ACTIVE_LEVEL_RST;
			mode_select <= `MODE_NONE;
		end
		else if (obj_req && obj_wr && !next_err)
		begin
			if (obj_index == `IDX_FUNC_SELECT)
				func_sel[sub_slot] <= obj_wdata[15:0];
			else if (obj_index == `IDX_FILTER_TIME)
				filter_us[sub_slot] <= obj_wdata[15:0];
			else if (obj_index == `IDX_ACTIVE_LEVEL)
				active_level <= obj_wdata[15:0];
			else if (obj_index == `IDX_MODE_SELECT)
				mode_select <= obj_wdata[7:0];
		end
	end

endmodule

// >>> design/input_debounce.v
`timescale 1ns/10ps
`include "drive_cfg_map.vh"

module input_debounce
(
	// clock and reset
	input wire core_clk,
	input wire arst_n,
	// timing
	input wire us_tick,
	input wire [15:0] filter_us,
	// level
	input wire raw,
	output reg level
);

	reg [15:0] stable_us;
	wire [15:0] next_stable_us;

	assign next_stable_us = stable_us + 16'h0001;

	// any bounce back to the accepted level restarts the window
	always @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			level <= `RAW_LEVEL_RST;
			stable_us <= 16'h0000;
		end
		else if (raw == level)
			stable_us <= 16'h0000;
		else if (us_tick)
		begin
			if (next_stable_us >= filter_us)
			begin
				level <= raw;
				stable_us <= 16'h0000;
			end
			else
				stable_us <= next_stable_us;
		end
	end

endmodule

// >>> design/mode_tracker.v
`timescale 1ns/10ps
`include "drive_cfg_map.vh"

module mode_tracker
(
	// clock and reset
	input wire core_clk,
	input wire arst_n,
	// mode request
	input wire [7:0] mode_select,
	output reg [7:0] mode_display,
	output wire mode_supported,
	// enable gating
	input wire enable_request,
	output wire enable_grant
);

	assign mode_supported = (mode_select == `MODE_PROFILE_POSITION) |
		(mode_select == `MODE_PROFILE_VELOCITY) |
		(mode_select == `MODE_HOMING) |
		(mode_select == `MODE_CYCLIC_SYNC_POSITION);

	// an unsupported request leaves the executing mode untouched
	always @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			mode_display <= `MODE_NONE;
		else if (mode_supported)
			mode_display <= mode_select;
	end

	assign enable_grant = enable_request & mode_supported;

endmodule

// >>> pkg/drive_cfg_map.vh
`ifndef DRIVE_CFG_MAP_VH
`define DRIVE_CFG_MAP_VH

// object indexes
`define IDX_FUNC_SELECT 16'h2152
`define IDX_FILTER_TIME 16'h2153
`define IDX_ACTIVE_LEVEL 16'h2154
`define IDX_PHYS_STATE 16'h2155
`define IDX_MODE_SELECT 16'h6060
`define IDX_MODE_DISPLAY 16'h6061
`define IDX_FUNC_STATUS 16'h60FD
`define IDX_SUPPORTED_MODES 16'h6502

// number of inputs, also the highest sub-index of the per-input arrays
`define NUM_INPUTS 5
`define SUB_COUNT 8'h00
`define SUB_COUNT_VALUE 32'h00000005

// operation mode codes, shared by select and display
`define MODE_NONE 8'h00
`define MODE_PROFILE_POSITION 8'h01
`define MODE_PROFILE_VELOCITY 8'h03
`define MODE_HOMING 8'h06
`define MODE_CYCLIC_SYNC_POSITION 8'h08

// supported-modes bitmap bit positions
`define SUPP_BIT_PROFILE_POSITION 0
`define SUPP_BIT_PROFILE_VELOCITY 2
`define SUPP_BIT_HOMING 5
`define SUPP_BIT_CYCLIC_SYNC_POSITION 7

// input function codes
`define FN_NONE 16'h0000
`define FN_HOMING 16'h0001
`define FN_POS_LIMIT 16'h0002
`define FN_NEG_LIMIT 16'h0004
`define FN_EMERGENCY_STOP 16'h0008
`define FN_USER_DEFINED 16'h0010
`define FN_PROBE1 16'h0020
`define FN_PROBE2 16'h0040

// function select reset values
`define FUNC_RST_INPUT1 16'h0020
`define FUNC_RST_INPUT2 16'h0001
`define FUNC_RST_INPUT3 16'h0002
`define FUNC_RST_INPUT4 16'h0004
`define FUNC_RST_INPUT5 16'h0010

// filter time in microseconds
`define FILTER_US_MIN 16'h0032
`define FILTER_US_MAX 16'hEA60
`define FILTER_US_RST 16'h03E8

// active level, cleared bit is active low
`define ACTIVE_LEVEL_RST 16'h0000
`define RAW_LEVEL_RST 1'b1

// function status bit positions
`define FS_NEG_LIMIT 0
`define FS_POS_LIMIT 1
`define FS_HOME 2
`define FS_QUICK_STOP 3
`define FS_USER_LSB 17
`define FS_PROBE1 26
`define FS_PROBE2 27

// timing
`define CLK_PERIOD_NS 8
`define MICROSECOND_NS 1000
`define US_TICK_CYCLES (`MICROSECOND_NS / `CLK_PERIOD_NS)

`endif

// >>> tb/bus_master.sv
`timescale 1ns/10ps
module bus_master
(
	// clock
	input wire core_clk,
	// request
	output reg obj_req,
	output reg obj_wr,
	output reg [15:0] obj_index,
	output reg [7:0] obj_sub,
	output reg [31:0] obj_wdata,
	// answer
	input wire obj_ack,
	input wire obj_err,
	input wire [31:0] obj_rdata
);
	reg [32:0] ans;
	initial
	begin
		obj_req = 1'b0;
		obj_wr = 1'b0;
		obj_index = 16'h0;
		obj_sub = 8'h0;
		obj_wdata = 32'h0;
	end
	// a missing acknowledge comes back as an error with inverted data
	task acc(input reg w, input reg [15:0] i, input reg [7:0] s, input reg [31:0] d);
	begin
		@(negedge core_clk);
		obj_req = 1'b1;
		obj_wr = w;
		obj_index = i;
		obj_sub = s;
		obj_wdata = d;
		@(negedge core_clk);
		ans = obj_ack ? {obj_err, obj_rdata} : {1'b1, ~obj_rdata};
		obj_req = 1'b0;
		obj_index = ~obj_index;
		obj_wdata = ~obj_wdata;
	end
	endtask
endmodule

// >>> tb/cfg_monitor.sv
`timescale 1ns/10ps
module cfg_monitor
(
	// clock and reset
	input wire core_clk,
	input wire arst_n,
	// object access
	input wire obj_req,
	input wire obj_wr,
	input wire [15:0] obj_index,
	input wire [31:0] obj_wdata,
	input wire obj_ack,
	input wire obj_err,
	input wire [31:0] obj_rdata,
	// motion side
	input wire enable_request,
	input wire enable_grant,
	input wire [7:0] active_mode
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	wire rd = obj_req & ~obj_wr;
	wire wr = obj_req & obj_wr;
	wire [7:0] wm = obj_wdata[7:0];
	wire wsup = wm == 8'h01 || wm == 8'h03 || wm == 8'h06 || wm == 8'h08;
	wire msel = wr && obj_index == 16'h6060 && obj_wdata[31:8] == 24'h0;
	wire asup = active_mode == 8'h01 || active_mode == 8'h03 || active_mode == 8'h06
		|| active_mode == 8'h08;
	wire roi = obj_index == 16'h2155 || obj_index == 16'h6061 || obj_index == 16'h60FD
		|| obj_index == 16'h6502;
	a_ack_one_cycle: assert property (obj_req |=> obj_ack)
		else $error("no acknowledge one cycle after request");
	a_idle_quiet: assert property (!obj_req |=> !obj_ack && !obj_err && obj_rdata == 32'h0)
		else $error("answer without request");
	a_err_has_ack: assert property (obj_err |-> obj_ack)
		else $error("error flag without acknowledge");
	a_bitmap_value: assert property (rd && obj_index == 16'h6502 |=> obj_rdata == 32'h000000A5)
		else $error("supported modes bitmap wrong");
	a_ro_write_refused: assert property (wr && roi |=> obj_err)
		else $error("write to read-only object accepted");
	a_mode_switch: assert property (msel && wsup |=> ##1 {24'h0, active_mode} == $past(obj_wdata, 2))
		else $error("executing mode did not follow select");
	a_unsupported_kept: assert property (msel && !wsup |=> !enable_grant ##1 $stable(active_mode))
		else $error("unsupported mode changed state");
	// the executing mode trails the selection by one cycle, so it is checked one edge later
	a_grant_needs_mode: assert property (enable_grant |-> enable_request ##1 asup)
		else $error("grant without request or supported mode");
	wire rsv_zero = obj_rdata[16:4] == 13'h0 && obj_rdata[25:22] == 4'h0
		&& obj_rdata[31:28] == 4'h0;
	a_status_reserved: assert property (rd && obj_index == 16'h60FD |=> rsv_zero)
		else $error("reserved function status bits set");
	a_phys_upper_zero: assert property (rd && obj_index == 16'h2155 |=> obj_rdata[31:5] == 27'h0)
		else $error("physical state upper bits set");
endmodule
bind drive_mode_and_input_config cfg_monitor mon
(
	.core_clk(core_clk), .arst_n(arst_n), .obj_req(obj_req), .obj_wr(obj_wr),
	.obj_index(obj_index), .obj_wdata(obj_wdata), .obj_ack(obj_ack), .obj_err(obj_err),
	.obj_rdata(obj_rdata), .enable_request(enable_request), .enable_grant(enable_grant),
	.active_mode(active_mode)
);

// >>> tb/drive_mode_and_input_config_test.sv
`timescale 1ns/10ps
module drive_mode_and_input_config_test;
	reg core_clk;
	reg arst_n;
	reg [4:0] input_pin;
	reg enable_request;
	wire obj_req, obj_wr, obj_ack, obj_err, enable_grant;
	wire [15:0] obj_index;
	wire [7:0] obj_sub;
	wire [7:0] active_mode;
	wire [31:0] obj_wdata, obj_rdata;
	wire [5:0] fn;
	integer fail_count, n_compared, i;
	reg [31:0] v;
	reg [4:0] lvl, a;
	reg sw;
	drive_mode_and_input_config dut
	(
		.core_clk(core_clk), .arst_n(arst_n), .obj_req(obj_req), .obj_wr(obj_wr),
		.obj_index(obj_index), .obj_sub(obj_sub), .obj_wdata(obj_wdata), .obj_ack(obj_ack),
		.obj_err(obj_err), .obj_rdata(obj_rdata), .input_pin(input_pin),
		.enable_request(enable_request), .enable_grant(enable_grant), .active_mode(active_mode),
		.limit_negative(fn[0]), .limit_positive(fn[1]), .home_signal(fn[2]),
		.quick_stop(fn[3]), .probe1(fn[4]), .probe2(fn[5])
	);
	bus_master m
	(
		.core_clk(core_clk), .obj_req(obj_req), .obj_wr(obj_wr), .obj_index(obj_index),
		.obj_sub(obj_sub), .obj_wdata(obj_wdata), .obj_ack(obj_ack), .obj_err(obj_err),
		.obj_rdata(obj_rdata)
	);
	// s selects the second mapping: input 1 user, input 3 quick stop, input 4 probe 2
	function [31:0] fs_exp(input [4:0] x, input s);
	begin
		fs_exp = 32'h0;
		fs_exp[0] = x[3] & ~s;
		fs_exp[1] = x[2] & ~s;
		fs_exp[2] = x[1];
		fs_exp[3] = x[2] & s;
		fs_exp[17] = x[0] & s;
		fs_exp[21] = x[4];
		fs_exp[26] = x[0] & ~s;
		fs_exp[27] = x[3] & s;
	end
	endfunction
	task chk(input [8*5:1] nm, input [31:0] seen, input [31:0] exp);
	begin
		n_compared = n_compared + 1;
		if (seen !== exp)
		begin
			fail_count = fail_count + 1;
			$display("[ERR] %0s expected %h seen %h", nm, exp, seen);
		end
	end
	endtask
	// writes answer with zero data
	task ax(input w, input [15:0] i, input [7:0] s, input [31:0] d, input ee, input [31:0] er);
	begin
		m.acc(w, i, s, d);
		chk("err", {31'h0, m.ans[32]}, {31'h0, ee});
		chk("data", m.ans[31:0], ee ? 32'h0 : er);
	end
	endtask
	task tally_and_finish;
	begin
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	end
	endtask
	task settle_and_check;
	begin
		repeat (55 * 125) @(negedge core_clk);
		a = ~(input_pin ^ lvl);
		ax(0, 16'h2155, 0, 0, 0, {27'h0, a});
		ax(0, 16'h60FD, 0, 0, 0, fs_exp(a, sw));
		v = fs_exp(a, sw);
		chk("pins", {26'h0, fn}, {26'h0, v[27], v[26], v[3:0]});
	end
	endtask
	initial
	begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	initial
	begin
		#600000;
		fail_count = fail_count + 1;
		tally_and_finish;
	end
	initial
	begin
		fail_count = 0;
		n_compared = 0;
		arst_n = 1'b0;
		input_pin = 5'h1F;
		enable_request = 1'b0;
		lvl = 5'h0;
		sw = 1'b0;
		v = $urandom(32'hE4C6);
		repeat (10) @(negedge core_clk);
		arst_n = 1'b1;
		for (i = 1; i <= 5; i = i + 1)
		begin
			v = 32'h1 << ((32'h00042105 >> (4 * i - 4)) & 32'hF);
			ax(0, 16'h2152, i, 0, 0, v);
			ax(0, 16'h2153, i, 0, 0, 32'h3E8);
		end
		ax(0, 16'h2152, 0, 0, 0, 32'h5);
		ax(0, 16'h2154, 0, 0, 0, 32'h0);
		ax(0, 16'h6502, 0, 0, 0, 32'hA5);
		ax(0, 16'h6061, 0, 0, 0, 32'h0);
		ax(0, 16'h1234, 0, 0, 1, 0);
		ax(0, 16'h2152, 6, 0, 1, 0);
		ax(1, 16'h6502, 0, 32'hFFFFFFFF, 1, 0);
		ax(1, 16'h60FD, 0, 32'h1, 1, 0);
		ax(1, 16'h2152, 0, 32'h7, 1, 0);
		for (i = 0; i < 7; i = i + 1)
		begin
			ax(1, 16'h2152, 2, 32'h1 << i, 0, 0);
			ax(0, 16'h2152, 2, 0, 0, 32'h1 << i);
		end
		ax(1, 16'h2152, 2, 32'h3, 1, 0);
		ax(1, 16'h2152, 2, 32'h10001, 1, 0);
		ax(0, 16'h2152, 2, 0, 0, 32'h40);
		ax(1, 16'h2152, 2, 32'h0, 0, 0);
		ax(0, 16'h2152, 2, 0, 0, 32'h0);
		ax(1, 16'h2152, 2, 32'h1, 0, 0);
		ax(1, 16'h2153, 1, 32'd49, 1, 0);
		ax(1, 16'h2153, 1, 32'd60001, 1, 0);
		ax(1, 16'h2153, 1, 32'd60000, 0, 0);
		ax(0, 16'h2153, 1, 0, 0, 32'd60000);
		for (i = 1; i <= 5; i = i + 1)
			ax(1, 16'h2153, i, 32'd50, 0, 0);
		ax(1, 16'h2154, 0, 32'h10000, 1, 0);
		enable_request = 1'b1;
		// mapping is fixed here, so nothing to remap after a mode change
		for (i = 0; i < 4; i = i + 1)
		begin
			v = (32'h08060301 >> (8 * i)) & 32'hFF;
			ax(1, 16'h6060, 0, v, 0, 0);
			ax(0, 16'h6061, 0, 0, 0, v);
			chk("mode", {24'h0, active_mode}, v);
			chk("grant", {31'h0, enable_grant}, 32'h1);
		end
		ax(1, 16'h6060, 0, 32'h2, 0, 0);
		ax(1, 16'h6060, 0, 32'h103, 1, 0);
		ax(0, 16'h6060, 0, 0, 0, 32'h2);
		ax(0, 16'h6061, 0, 0, 0, 32'h8);
		chk("grant", {31'h0, enable_grant}, 32'h0);
		input_pin = 5'h1E;
		repeat (40 * 125) @(negedge core_clk);
		chk("pins", {26'h0, fn}, 32'h0);
		settle_and_check;
		for (i = 0; i < 3; i = i + 1)
		begin
			lvl = $urandom;
			ax(1, 16'h2154, 0, {27'h0, lvl}, 0, 0);
			if (i == 2)
			begin
				ax(1, 16'h2152, 1, 32'h10, 0, 0);
				ax(1, 16'h2152, 3, 32'h8, 0, 0);
				ax(1, 16'h2152, 4, 32'h40, 0, 0);
				sw = 1'b1;
			end
			input_pin = $urandom;
			repeat (30 * 125) @(negedge core_clk);
			input_pin = $urandom;
			settle_and_check;
		end
		tally_and_finish;
	end
endmodule
